// ---- verilog/rpd_reset_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// - sample reset pin three times at 8 Hz
// - three lows clear and hold counter
// - three highs start counter count-up
// - pulses of two periods or less rejected
// - debounced reset result is active low
// - pin low drives oscillation start high
// - low for 500 ms asserts oscillation start
// - start drops within 500 ms after release
// - oscillation start only for loop/handshake variants
// - interval selects captured once at release
// - count start may lag up to about 375 ms
module rpd_reset_debounce #(
    parameter rpd_pkg::rpd_timeout_t TIMEOUT_KIND = rpd_pkg::RPD_TO_ONE_SHOT,
    parameter logic [31:0] OSC_RELEASE_CYC = rpd_pkg::OSC_RELEASE_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic timer_reset_n_in,
    input wire logic osc_32k_in,
    input wire logic interval_select_lo_in,
    input wire logic interval_select_hi_in,
    output logic counter_clear_n_out,
    output logic count_run_out,
    output logic count_start_out,
    output logic [1:0] interval_sel_out,
    output logic osc_start_out,
    output logic sample_tick_out
);

    // raw pins in, settled levels out
    rpd_sync_if sync_bus ();

    logic pin_lvl;
    logic osc_lvl;
    logic sel_lo_lvl;
    logic sel_hi_lvl;

    // gather the raw pins into one word; a single process keeps one driver on it
    always_comb begin
        sync_bus.raw = rpd_pkg::SYNC_RST;
        sync_bus.raw[rpd_pkg::SYNC_RST_PIN] = timer_reset_n_in;
        sync_bus.raw[rpd_pkg::SYNC_OSC] = osc_32k_in;
        sync_bus.raw[rpd_pkg::SYNC_SEL_LO] = interval_select_lo_in;
        sync_bus.raw[rpd_pkg::SYNC_SEL_HI] = interval_select_hi_in;
    end

    // settled levels that the control logic reads
    assign pin_lvl = sync_bus.level[rpd_pkg::SYNC_RST_PIN];
    assign osc_lvl = sync_bus.level[rpd_pkg::SYNC_OSC];
    assign sel_lo_lvl = sync_bus.level[rpd_pkg::SYNC_SEL_LO];
    assign sel_hi_lvl = sync_bus.level[rpd_pkg::SYNC_SEL_HI];

    // every pin passes the three-flop chain before any logic looks at it;
    // the selects ride the same chain, so they settle with the reset pin
    rpd_pin_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .sig(sync_bus.sync)
    );

    // ---- crystal divider ----
    // the crystal is handled as data rather than as a second clock: its settled
    // level is edge-detected here, which keeps one clock domain but needs the
    // crystal to hold each level for at least two system clocks
    logic osc_prev_r;
    logic osc_prev_nxt;
    logic [rpd_pkg::DIV_W-1:0] div_r;
    logic [rpd_pkg::DIV_W-1:0] div_nxt;
    logic tick_r;
    logic tick_nxt;

    // count crystal rising edges; one tick every 4096 of them
    // the tick lasts one system clock, whatever the crystal's duty
    always_comb begin
        osc_prev_nxt = osc_lvl;
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (osc_lvl && !osc_prev_r) begin
            if (div_r == rpd_pkg::DIV_LAST) begin
                div_nxt = rpd_pkg::DIV_RST;
                tick_nxt = 1'b1;
            end else begin
                div_nxt = div_r + 12'h0_001;
            end
        end
    end

    // reset leaves the edge detector at the synchroniser's own reset level,
    // so no false crystal edge is counted right after release
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_prev_r <= 1'b0;
            div_r <= rpd_pkg::DIV_RST;
            tick_r <= 1'b0;
        end else begin
            osc_prev_r <= osc_prev_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ---- debounce sampler ----
    // shift holds the last three samples, newest in bit zero
    logic [rpd_pkg::DEB_SAMPLES-1:0] shift_r;
    logic [rpd_pkg::DEB_SAMPLES-1:0] shift_nxt;
    logic deb_r;
    logic deb_nxt;
    logic start_r;
    logic start_nxt;
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;

    // a level is accepted only when three ticks in a row saw it, so a pulse
    // spanning two ticks at most never moves the result; the lag this costs
    // (up to two ticks plus a partial one) delays the first count start;
    // mixed samples leave the result alone
    always_comb begin
        shift_nxt = shift_r;
        deb_nxt = deb_r;
        start_nxt = 1'b0;
        sel_nxt = sel_r;
        if (tick_r) begin
            shift_nxt = {shift_r[rpd_pkg::DEB_SAMPLES-2:0], pin_lvl};
            if (shift_nxt == rpd_pkg::DEB_ALL_LOW) begin
                deb_nxt = 1'b0;
            end else if (shift_nxt == rpd_pkg::DEB_ALL_HIGH) begin
                deb_nxt = 1'b1;
            end
        end
        if (deb_nxt && !deb_r) begin
            start_nxt = 1'b1;
            sel_nxt = {sel_hi_lvl, sel_lo_lvl};
        end
    end

    // result starts low so the counter stays held until a high is confirmed,
    // and with the shift cleared too the first high needs three fresh ticks
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_r <= rpd_pkg::DEB_SHIFT_RST;
            deb_r <= rpd_pkg::DEB_LEVEL_RST;
            start_r <= 1'b0;
            sel_r <= rpd_pkg::SEL_RST;
        end else begin
            shift_r <= shift_nxt;
            deb_r <= deb_nxt;
            start_r <= start_nxt;
            sel_r <= sel_nxt;
        end
    end

    // ---- oscillation start request ----
    // only the loop and handshake variants may lack power-on detection, so
    // the toggle variant never raises the request
    localparam logic OSC_FEATURE = (TIMEOUT_KIND == rpd_pkg::RPD_TO_ONE_SHOT) ||
                                   (TIMEOUT_KIND == rpd_pkg::RPD_TO_HANDSHAKE);

    // state and release wait of the request
    rpd_pkg::rpd_osc_state_t osc_st_r;
    rpd_pkg::rpd_osc_state_t osc_st_nxt;
    logic [rpd_pkg::REL_W-1:0] rel_r;
    logic [rpd_pkg::REL_W-1:0] rel_nxt;

    // runs on the system clock, since the crystal may not be running yet;
    // a low asserts the request at once, which also covers the 500 ms hold;
    // any low restarts the release wait, so chatter on release only stretches
    // the request, and the wait itself stays well inside the 500 ms bound
    always_comb begin
        osc_st_nxt = osc_st_r;
        rel_nxt = rel_r;
        case (osc_st_r)
            rpd_pkg::RPD_OSC_IDLE: begin
                rel_nxt = rpd_pkg::REL_RST;
                if (!pin_lvl && OSC_FEATURE) begin
                    osc_st_nxt = rpd_pkg::RPD_OSC_START;
                end
            end
            rpd_pkg::RPD_OSC_START: begin
                if (!pin_lvl) begin
                    rel_nxt = rpd_pkg::REL_RST;
                end else if (rel_r >= OSC_RELEASE_CYC - rpd_pkg::REL_ONE) begin
                    osc_st_nxt = rpd_pkg::RPD_OSC_IDLE;
                    rel_nxt = rpd_pkg::REL_RST;
                end else begin
                    rel_nxt = rel_r + rpd_pkg::REL_ONE;
                end
            end
            default: begin
                osc_st_nxt = rpd_pkg::RPD_OSC_IDLE;
                rel_nxt = rpd_pkg::REL_RST;
            end
        endcase
    end

    // request register; reset returns to idle with the wait cleared
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_st_r <= rpd_pkg::RPD_OSC_IDLE;
            rel_r <= rpd_pkg::REL_RST;
        end else begin
            osc_st_r <= osc_st_nxt;
            rel_r <= rel_nxt;
        end
    end

    // outputs; all but osc_start_out come straight from flip-flops
    // osc_start_out compares both bits of a one-hot state, and neither in-between code matches, so it cannot glitch;
    // count_run_out repeats the debounced level as the count enable
    assign counter_clear_n_out = deb_r;
    assign count_run_out = deb_r;
    assign count_start_out = start_r;
    assign interval_sel_out = sel_r;
    assign osc_start_out = (osc_st_r == rpd_pkg::RPD_OSC_START);
    assign sample_tick_out = tick_r;

endmodule

`default_nettype wire

// ---- verilog/rpd_pkg.sv ----
`default_nettype none

package rpd_pkg;

    // system clock and time figures
    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned OSC_RELEASE_MS = 250;
    localparam int unsigned OSC_RELEASE_CYC = SYS_CLK_HZ / 1000 * OSC_RELEASE_MS;

    // crystal divider: 32.768 kHz / 4096 = 8 Hz sampling tick
    localparam int unsigned DIV_W = 12;
    localparam logic [DIV_W-1:0] DIV_LAST = 12'h0_FFF;
    localparam logic [DIV_W-1:0] DIV_RST = 12'h0_000;

    // debounce sampler
    localparam int unsigned DEB_SAMPLES = 3;
    localparam logic [DEB_SAMPLES-1:0] DEB_ALL_LOW = 3'h0;
    localparam logic [DEB_SAMPLES-1:0] DEB_ALL_HIGH = 3'h7;
    localparam logic [DEB_SAMPLES-1:0] DEB_SHIFT_RST = 3'h0;
    localparam logic DEB_LEVEL_RST = 1'b0;

    // pin synchroniser: bit positions of the conditioned inputs
    localparam int unsigned SYNC_W = 4;
    localparam int unsigned SYNC_RST_PIN = 0;
    localparam int unsigned SYNC_OSC = 1;
    localparam int unsigned SYNC_SEL_LO = 2;
    localparam int unsigned SYNC_SEL_HI = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;

    // release timer
    localparam int unsigned REL_W = 32;
    localparam logic [REL_W-1:0] REL_RST = 32'h0000_0000;
    localparam logic [REL_W-1:0] REL_ONE = 32'h0000_0001;

    // interval select capture
    localparam logic [1:0] SEL_RST = 2'h0;

    // interrupt time-out option of the variant
    typedef enum logic [2:0] {
        RPD_TO_ONE_SHOT = 3'b001,
        RPD_TO_HANDSHAKE = 3'b010,
        RPD_TO_TOGGLE = 3'b100
    } rpd_timeout_t;

    // oscillation start request state
    typedef enum logic [1:0] {
        RPD_OSC_IDLE = 2'b01,
        RPD_OSC_START = 2'b10
    } rpd_osc_state_t;

endpackage

`default_nettype wire

// ---- verilog/rpd_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// carries raw pins into the synchroniser and settled levels back out
interface rpd_sync_if;
    logic [rpd_pkg::SYNC_W-1:0] raw;
    logic [rpd_pkg::SYNC_W-1:0] level;
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface

`default_nettype wire

// ---- verilog/rpd_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rpd_pin_sync (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    rpd_sync_if.sync sig
);

    logic [rpd_pkg::SYNC_W-1:0] s1_r;
    logic [rpd_pkg::SYNC_W-1:0] s2_r;
    logic [rpd_pkg::SYNC_W-1:0] s3_r;
    logic [rpd_pkg::SYNC_W-1:0] level_r;
    logic [rpd_pkg::SYNC_W-1:0] level_nxt;

    // a bit changes only once stages two and three agree; stage one feeds stage two only
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < rpd_pkg::SYNC_W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
    end

    // three-stage chain, constant reset only
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_r <= rpd_pkg::SYNC_RST;
            s2_r <= rpd_pkg::SYNC_RST;
            s3_r <= rpd_pkg::SYNC_RST;
            level_r <= rpd_pkg::SYNC_RST;
        end else begin
            s1_r <= sig.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign sig.level = level_r;

endmodule

`default_nettype wire

// ---- bench/rpd_props_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the debounce block
module rpd_props #(
    parameter rpd_pkg::rpd_timeout_t TIMEOUT_KIND = rpd_pkg::RPD_TO_ONE_SHOT,
    parameter logic [31:0] OSC_RELEASE_CYC = 32'h0000_0010
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic timer_reset_n_in,
    input wire logic counter_clear_n_out,
    input wire logic count_run_out,
    input wire logic count_start_out,
    input wire logic [1:0] interval_sel_out,
    input wire logic osc_start_out,
    input wire logic sample_tick_out
);
    // only the loop and handshake variants may raise the oscillation start request
    localparam logic OSC_EN = (TIMEOUT_KIND == rpd_pkg::RPD_TO_ONE_SHOT) ||
        (TIMEOUT_KIND == rpd_pkg::RPD_TO_HANDSHAKE);
    logic [31:0] hi_cnt_r;
    logic [31:0] hi_cnt_nxt;
    // consecutive high pin cycles, saturating so a long run never wraps
    always_comb begin
        hi_cnt_nxt = hi_cnt_r + 32'h0000_0001;
        if (!timer_reset_n_in) hi_cnt_nxt = 32'h0000_0000;
        if (hi_cnt_r == 32'hFFFF_FFFF) hi_cnt_nxt = hi_cnt_r;
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) hi_cnt_r <= 32'h0000_0000;
        else hi_cnt_r <= hi_cnt_nxt;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // low long enough to pass the synchroniser
    sequence s_pin_low; !timer_reset_n_in [*6]; endsequence
    sequence s_tick_quiet; !sample_tick_out [*8]; endsequence
    property p_osc_on; s_pin_low |=> (osc_start_out == OSC_EN); endproperty
    property p_osc_off; hi_cnt_r > OSC_RELEASE_CYC + 32'h0000_0008 |-> !osc_start_out; endproperty
    property p_tick_gap; sample_tick_out |=> s_tick_quiet; endproperty
    property p_clear_tick; $changed(counter_clear_n_out) |-> $past(sample_tick_out); endproperty
    property p_start; count_start_out |-> counter_clear_n_out && !$past(counter_clear_n_out);
    endproperty
    property p_rise; $rose(counter_clear_n_out) |-> count_start_out; endproperty
    property p_run; count_run_out == counter_clear_n_out; endproperty
    property p_sel; $changed(interval_sel_out) |-> count_start_out; endproperty
    property p_osc_none; !OSC_EN |-> !osc_start_out; endproperty
    a_osc_on: assert property (p_osc_on) else $error("osc start low while pin low");
    a_osc_off: assert property (p_osc_off) else $error("osc start stuck high");
    a_tick_gap: assert property (p_tick_gap) else $error("sample tick too close");
    a_clear_tick: assert property (p_clear_tick) else $error("clear moved off tick");
    a_start: assert property (p_start) else $error("start without rise");
    a_rise: assert property (p_rise) else $error("rise without start");
    a_run: assert property (p_run) else $error("run differs from clear");
    a_sel: assert property (p_sel) else $error("select moved while counting");
    a_osc_none: assert property (p_osc_none) else $error("osc start in toggle variant");
endmodule
`default_nettype wire

// ---- bench/rpd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host driving the timer reset pin; powers up holding it low
module rpd_host_model (
    input wire logic clk_in,
    input wire logic hold_low_in,
    output logic timer_reset_n_out
);
    initial timer_reset_n_out = 1'b0;
    // level follows the bench request; the bench chooses how long it is held
    always @(posedge clk_in) timer_reset_n_out <= ~hold_low_in;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] REL_CYC = 32'h0000_0010;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic osc_r = 1'b0;
    logic [2:0] div_r = 3'h0;
    logic hold_low = 1'b1;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b0;
    logic pin_n, clear_n, run, start, osc_start, tick, osc_tgl;
    logic [1:0] sel;
    logic [1:0] e;
    logic [31:0] r;
    logic [1:0] exp_q[$];
    int ticks = 0;
    int cycles = 0;
    int num_errors = 0;
    int compares = 0;
    rpd_host_model host (.clk_in(clk_sys_in), .hold_low_in(hold_low), .timer_reset_n_out(pin_n));
    rpd_reset_debounce #(.OSC_RELEASE_CYC(REL_CYC)) dut (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .timer_reset_n_in(pin_n), .osc_32k_in(osc_r),
        .interval_select_lo_in(sel_lo), .interval_select_hi_in(sel_hi),
        .counter_clear_n_out(clear_n), .count_run_out(run), .count_start_out(start),
        .interval_sel_out(sel), .osc_start_out(osc_start), .sample_tick_out(tick));
    // toggle variant beside it: same pins, its request must never rise
    rpd_reset_debounce #(.TIMEOUT_KIND(rpd_pkg::RPD_TO_TOGGLE), .OSC_RELEASE_CYC(REL_CYC))
        dut_tgl (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .timer_reset_n_in(pin_n),
        .osc_32k_in(osc_r), .interval_select_lo_in(sel_lo), .interval_select_hi_in(sel_hi),
        .counter_clear_n_out(), .count_run_out(), .count_start_out(),
        .interval_sel_out(), .osc_start_out(osc_tgl), .sample_tick_out());
    always #5 clk_sys_in = ~clk_sys_in;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task wrap_up;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // crystal stand-in: two clocks a half period, the least the synchroniser
    // still follows; a tick then comes every 16384 clocks, so four fit the run
    // run ceiling: four ticks plus margin, a hang lands on the fail verdict
    always @(posedge clk_sys_in) begin
        div_r <= (div_r == 3'h1) ? 3'h0 : div_r + 3'h1;
        if (div_r == 3'h1) osc_r <= ~osc_r;
        if (tick === 1'b1) ticks <= ticks + 1;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            wrap_up;
        end
    end
    // result watcher: oldest noted select against what the block captured
    always @(posedge clk_sys_in) begin
        if (start === 1'b1) begin
            if (exp_q.size() == 0) check(8'(sel), 8'hFF);
            else check(8'(sel), 8'(exp_q.pop_front()));
            check(8'(ticks), 8'h03);
            check(8'(clear_n), 8'h01);
            check(8'(run), 8'h01);
        end
    end
    initial begin
        void'($urandom(52289));
        cyc(4);
        reset_n_in <= 1'b1;
        cyc(20);
        @(negedge clk_sys_in);
        check(8'(osc_start), 8'h01);
        check(8'(clear_n), 8'h00);
        check(8'(run), 8'h00);
        check(8'(osc_tgl), 8'h00);
        @(posedge clk_sys_in);
        hold_low <= 1'b0;
        cyc(int'(REL_CYC) + 10);
        @(negedge clk_sys_in);
        check(8'(osc_start), 8'h00);
        $display("test osc start done");
        r = $urandom;
        e = r[1:0];
        @(posedge clk_sys_in);
        sel_lo <= r[0];
        sel_hi <= r[1];
        exp_q.push_back(e);
        // three high samples needed since the sampler wakes at all low
        for (int i = 0; i < 140000 && start !== 1'b1; i++) @(negedge clk_sys_in);
        r = $urandom;
        @(posedge clk_sys_in);
        sel_lo <= ~r[0];
        sel_hi <= r[1];
        hold_low <= 1'b1;
        $display("test count start done");
        // a low covering a single sample must not clear
        @(negedge clk_sys_in);
        for (int i = 0; i < 50000 && tick !== 1'b1; i++) @(negedge clk_sys_in);
        cyc(50);
        hold_low <= 1'b0;
        cyc(4);
        @(negedge clk_sys_in);
        check(8'(clear_n), 8'h01);
        check(8'(sel), 8'(e));
        check(8'(run), 8'h01);
        check(8'(exp_q.size()), 8'h00);
        $display("test short pulse done");
        wrap_up;
    end
endmodule
bind rpd_reset_debounce rpd_props #(.TIMEOUT_KIND(TIMEOUT_KIND),
    .OSC_RELEASE_CYC(OSC_RELEASE_CYC)) u_props (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .timer_reset_n_in(timer_reset_n_in),
    .counter_clear_n_out(counter_clear_n_out), .count_run_out(count_run_out),
    .count_start_out(count_start_out), .interval_sel_out(interval_sel_out),
    .osc_start_out(osc_start_out), .sample_tick_out(sample_tick_out));
`default_nettype wire
